// file: src/afe_pkg.sv
// Constants, types and helper functions for the ADC input front end.
// Assumes an APB slave with 32-bit data and word-aligned register access.
// Summary of operation
// - Each port has a qualify pin and four selectable qualify modes.
// - Level-high mode accepts samples only while the qualify pin is high.
// - Fall mode takes the sample on the edge after qualify goes low.
// - Rise mode takes the sample on the edge after qualify goes high.
// - Blank mode substitutes zero data while the qualify pin is low.
// - Transition modes take one sample per qualifying edge, ignore others.
// - Every clock still produces a downstream filter computation step.
// - Level flag rises when monitored level exceeds the upper threshold.
// - With flag set, falling below lower threshold starts the dwell count.
// - Rising above lower threshold while counting stops and resets count.
// - Dwell count reaching zero clears the level flag.
// - Quiet gain bits 9:5 when flag clear, loud bits 4:0 when set.
// - Four level detectors, each free to monitor any of four streams.
// - Level detection uses raw input samples ahead of any filtering.
// - Gain change lags the flag by a programmable zero to seven clocks.
// - Ports take 14-bit signed mantissa, 3-bit exponent and qualify.
// - Exponent is adjusted by the 5-bit gain before the resampling filter.
// - Port samples are captured on the rising clock edge.
// - Invert clear shifts right by exponent plus gain, set shifts right by seven minus exponent plus gain, modulo 32.
package afe_pkg;
    localparam int DATA_W = 14;
    localparam int EXP_W = 3;
    localparam int SCALE_W = 5;
    localparam int DWELL_W = 16;
    localparam int DLY_W = 3;
    localparam int NCH = 4;
    localparam int PADDR_W = 10;
    localparam logic [7:0] IDX_CTRL = 8'h90;
    localparam logic [7:0] IDX_SCALE = 8'h92;
    localparam logic [7:0] IDX_LCFG0 = 8'h94;
    localparam logic [7:0] IDX_THR0 = 8'h98;
    localparam logic [7:0] IDX_DWELL0 = 8'h9C;
    localparam logic [7:0] IDX_STATUS = 8'hA0;
    localparam int SCALE_LOUD_LSB = 0;
    localparam int SCALE_QUIET_LSB = 5;
    localparam int CTRL_MODE_A_LSB = 0;
    localparam int CTRL_MODE_B_LSB = 2;
    localparam int CTRL_ILV_A_BIT = 4;
    localparam int CTRL_ILV_B_BIT = 5;
    localparam int CTRL_INV_BIT = 6;
    localparam int LCFG_SRC_LSB = 0;
    localparam int LCFG_DLY_LSB = 2;
    localparam int THR_LOWER_LSB = 0;
    localparam int THR_UPPER_LSB = 16;
    localparam int STAT_GAIN_LSB = 4;
    localparam logic [15:0] SCALE_RST = 16'h0000;
    localparam logic [6:0] CTRL_RST = 7'h0A;
    localparam logic [4:0] LCFG_RST = 5'h00;
    localparam logic [31:0] THR_RST = 32'h3FFF_0000;
    localparam logic [15:0] DWELL_RST = 16'h0000;
    localparam logic [4:0] EXP_TOP = 5'h07;

    typedef enum logic [1:0] {
        AFE_QUAL_FALL = 2'b00,
        AFE_QUAL_RISE = 2'b01,
        AFE_QUAL_HIGH = 2'b10,
        AFE_QUAL_BLANK = 2'b11
    } afe_qual_t;

    typedef enum logic [1:0] {
        AFE_LD_IDLE = 2'b00,
        AFE_LD_HELD = 2'b01,
        AFE_LD_COUNT = 2'b10
    } afe_ld_state_t;

    // Magnitude of a signed mantissa; the most negative code maps to 8192.
    function automatic logic [DATA_W-1:0] afe_mag(
        input logic [DATA_W-1:0] d
    );
        afe_mag = d[DATA_W-1] ? DATA_W'(-d) : d;
    endfunction

    // Net right shift; the 5-bit wrap gives the modulo 32 for free.
    function automatic logic [4:0] afe_shift_amt(
        input logic [EXP_W-1:0] e,
        input logic [SCALE_W-1:0] s,
        input logic inv
    );
        if (inv) begin
            afe_shift_amt = 5'(EXP_TOP - {2'b00, e} + s);
        end else begin
            afe_shift_amt = 5'({2'b00, e} + s);
        end
    endfunction
endpackage

// file: src/afe_lvl_if.sv
// Bundle between the front end top and one level detector.
// Assumes both ends run on the single sample clock.
`timescale 1ns/10ps
interface afe_lvl_if;
    logic [afe_pkg::DATA_W-1:0] mag;
    logic [afe_pkg::DATA_W-1:0] upper;
    logic [afe_pkg::DATA_W-1:0] lower;
    logic [afe_pkg::DWELL_W-1:0] dwell;
    logic [afe_pkg::DLY_W-1:0] dly;
    logic flag;
    logic gain_flag;
    modport det (input mag, input upper, input lower, input dwell,
        input dly, output flag, output gain_flag);
    modport ctl (output mag, output upper, output lower, output dwell,
        output dly, input flag, input gain_flag);
endinterface

// file: src/afe_level_det.sv
// One level detector: threshold hysteresis, dwell counter, gain delay.
// Assumes the monitored magnitude is held between samples by the top.
`timescale 1ns/10ps
module afe_level_det (
    input wire logic pclk,
    input wire logic presetn,
    afe_lvl_if.det lvl
);
    afe_pkg::afe_ld_state_t state_reg, state_next;
    logic [afe_pkg::DWELL_W-1:0] cnt_reg, cnt_next;
    logic [6:0] hist_reg, hist_next;
    logic over_upper, under_lower;

    assign over_upper = lvl.mag > lvl.upper;
    assign under_lower = lvl.mag < lvl.lower;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            afe_pkg::AFE_LD_IDLE: begin
                if (over_upper) begin
                    state_next = afe_pkg::AFE_LD_HELD;
                end
            end
            afe_pkg::AFE_LD_HELD: begin
                if (under_lower && !over_upper) begin
                    if (lvl.dwell == '0) begin
                        state_next = afe_pkg::AFE_LD_IDLE;
                    end else begin
                        cnt_next = lvl.dwell;
                        state_next = afe_pkg::AFE_LD_COUNT;
                    end
                end
            end
            afe_pkg::AFE_LD_COUNT: begin
                if (!under_lower || over_upper) begin
                    // Count is abandoned; a fresh drop must reload it.
                    state_next = afe_pkg::AFE_LD_HELD;
                end else if (cnt_reg == '0) begin
                    state_next = afe_pkg::AFE_LD_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = afe_pkg::AFE_LD_IDLE;
            end
        endcase
        hist_next = {hist_reg[5:0], lvl.flag};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= afe_pkg::AFE_LD_IDLE;
            cnt_reg <= '0;
            hist_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hist_reg <= hist_next;
        end
    end

    assign lvl.flag = state_reg != afe_pkg::AFE_LD_IDLE;
    assign lvl.gain_flag = (lvl.dly == '0) ? lvl.flag :
        hist_reg[3'(lvl.dly - 1'b1)];

    flag_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lvl.flag) |-> $past(over_upper))
        else $error("Level flag rose without upper threshold crossing.");
    flag_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(lvl.flag) |-> $past(under_lower) &&
        ($past(cnt_reg) == '0 || $past(lvl.dwell) == '0))
        else $error("Level flag fell before the dwell count ended.");
    count_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == afe_pkg::AFE_LD_COUNT && !under_lower) |=>
        state_reg == afe_pkg::AFE_LD_HELD)
        else $error("Dwell count kept running above lower threshold.");
    gain_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lvl.dly == 3'h2 && $past(lvl.dly) == 3'h2) |->
        lvl.gain_flag == $past(lvl.flag, 2))
        else $error("Gain flag does not lag level flag by two clocks.");
endmodule

// file: src/afe_scaler.sv
// Exponent scaling of one captured sample ahead of the resampling filter.
// Assumes a two's complement mantissa and an unsigned exponent.
`timescale 1ns/10ps
module afe_scaler (
    input wire logic [afe_pkg::DATA_W-1:0] data_in,
    input wire logic [afe_pkg::EXP_W-1:0] exponent_in,
    input wire logic [afe_pkg::SCALE_W-1:0] gain_shift,
    input wire logic exponent_invert,
    output logic [afe_pkg::DATA_W-1:0] data_out
);
    logic [4:0] amt;

    assign amt = afe_pkg::afe_shift_amt(exponent_in, gain_shift,
        exponent_invert);
    // Large shifts saturate to the sign, which is what the filter expects.
    assign data_out = $signed(data_in) >>> amt;
endmodule

// file: src/afe_front_end.sv
// Top of the ADC input front end: qualify, capture, level detect, scaling.
// Assumes ports are synchronous to pclk and registers are reached over APB.
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module afe_front_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [afe_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [afe_pkg::DATA_W-1:0] port_a_data,
    input wire logic [afe_pkg::EXP_W-1:0] port_a_exponent_in,
    input wire logic port_a_qualify,
    input wire logic [afe_pkg::DATA_W-1:0] port_b_data,
    input wire logic [afe_pkg::EXP_W-1:0] port_b_exponent_in,
    input wire logic port_b_qualify,
    output logic port_a_even_level_flag,
    output logic port_a_odd_level_flag,
    output logic port_b_even_level_flag,
    output logic port_b_odd_level_flag,
    output logic [afe_pkg::DATA_W-1:0] port_a_scaled,
    output logic port_a_scaled_valid,
    output logic [afe_pkg::DATA_W-1:0] port_b_scaled,
    output logic port_b_scaled_valid,
    output logic filter_step
);
    localparam int DW = afe_pkg::DATA_W;

    logic [15:0] scale_reg, scale_next;
    logic [6:0] ctrl_reg, ctrl_next;
    logic [4:0] lcfg_reg [afe_pkg::NCH], lcfg_next [afe_pkg::NCH];
    logic [31:0] thr_reg [afe_pkg::NCH], thr_next [afe_pkg::NCH];
    logic [15:0] dwell_reg [afe_pkg::NCH], dwell_next [afe_pkg::NCH];
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic [31:0] rd_val;
    logic hit;
    logic [7:0] idx;

    logic [DW-1:0] in_data [2];
    logic [afe_pkg::EXP_W-1:0] in_exp [2];
    logic in_q [2];
    afe_pkg::afe_qual_t mode [2];
    logic ilv [2];
    logic accept [2];
    logic q_prev_reg [2], q_prev_next [2];
    logic slot_reg [2], slot_next [2];
    logic [DW-1:0] cap_data_reg [2], cap_data_next [2];
    logic [afe_pkg::EXP_W-1:0] cap_exp_reg [2], cap_exp_next [2];
    logic cap_slot_reg [2], cap_slot_next [2];
    logic cap_valid_reg [2], cap_valid_next [2];
    logic [DW-1:0] mon_reg [afe_pkg::NCH], mon_next [afe_pkg::NCH];
    logic [DW-1:0] scaled [2];
    logic [afe_pkg::SCALE_W-1:0] gsel [2];
    logic [DW-1:0] out_data_reg [2];
    logic out_valid_reg [2];
    logic step_reg;
    logic [afe_pkg::NCH-1:0] flags, gflags;

    afe_lvl_if lvl [afe_pkg::NCH] ();

    assign idx = paddr[9:2];
    assign in_data[0] = port_a_data;
    assign in_data[1] = port_b_data;
    assign in_exp[0] = port_a_exponent_in;
    assign in_exp[1] = port_b_exponent_in;
    assign in_q[0] = port_a_qualify;
    assign in_q[1] = port_b_qualify;
    assign mode[0] = afe_pkg::afe_qual_t'(ctrl_reg[afe_pkg::CTRL_MODE_A_LSB
        +: 2]);
    assign mode[1] = afe_pkg::afe_qual_t'(ctrl_reg[afe_pkg::CTRL_MODE_B_LSB
        +: 2]);
    assign ilv[0] = ctrl_reg[afe_pkg::CTRL_ILV_A_BIT];
    assign ilv[1] = ctrl_reg[afe_pkg::CTRL_ILV_B_BIT];

    // Register read decode; unmapped indices answer with an error.
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        if (idx == afe_pkg::IDX_CTRL) begin
            rd_val = {25'h0000000, ctrl_reg};
        end else if (idx == afe_pkg::IDX_SCALE) begin
            rd_val = {16'h0000, scale_reg};
        end else if (idx == afe_pkg::IDX_STATUS) begin
            rd_val = {24'h000000, gflags, flags};
        end else if (idx[7:2] == afe_pkg::IDX_LCFG0[7:2]) begin
            rd_val = {27'h0000000, lcfg_reg[idx[1:0]]};
        end else if (idx[7:2] == afe_pkg::IDX_THR0[7:2]) begin
            rd_val = thr_reg[idx[1:0]];
        end else if (idx[7:2] == afe_pkg::IDX_DWELL0[7:2]) begin
            rd_val = {16'h0000, dwell_reg[idx[1:0]]};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        scale_next = scale_reg;
        ctrl_next = ctrl_reg;
        lcfg_next = lcfg_reg;
        thr_next = thr_reg;
        dwell_next = dwell_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (psel && !penable) begin
            rdata_next = pwrite ? 32'h0000_0000 : rd_val;
            err_next = !hit;
        end
        if (psel && penable && pwrite && hit) begin
            if (idx == afe_pkg::IDX_CTRL) begin
                ctrl_next = pwdata[6:0];
            end else if (idx == afe_pkg::IDX_SCALE) begin
                scale_next = pwdata[15:0];
            end else if (idx[7:2] == afe_pkg::IDX_LCFG0[7:2]) begin
                lcfg_next[idx[1:0]] = pwdata[4:0];
            end else if (idx[7:2] == afe_pkg::IDX_THR0[7:2]) begin
                thr_next[idx[1:0]] = {2'b00,
                    pwdata[afe_pkg::THR_UPPER_LSB +: DW], 2'b00,
                    pwdata[afe_pkg::THR_LOWER_LSB +: DW]};
            end else if (idx[7:2] == afe_pkg::IDX_DWELL0[7:2]) begin
                dwell_next[idx[1:0]] = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_reg <= afe_pkg::SCALE_RST;
            ctrl_reg <= afe_pkg::CTRL_RST;
            for (int i = 0; i < afe_pkg::NCH; i++) begin
                lcfg_reg[i] <= afe_pkg::LCFG_RST;
                thr_reg[i] <= afe_pkg::THR_RST;
                dwell_reg[i] <= afe_pkg::DWELL_RST;
            end
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else begin
            scale_reg <= scale_next;
            ctrl_reg <= ctrl_next;
            lcfg_reg <= lcfg_next;
            thr_reg <= thr_next;
            dwell_reg <= dwell_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    assign pready = penable;
    assign prdata = rdata_reg;
    assign pslverr = penable && err_reg;

    // Sample qualification and capture for both ports.
    always_comb begin
        mon_next = mon_reg;
        for (int p = 0; p < 2; p++) begin
            unique case (mode[p])
                afe_pkg::AFE_QUAL_FALL:
                    accept[p] = q_prev_reg[p] && !in_q[p];
                afe_pkg::AFE_QUAL_RISE:
                    accept[p] = !q_prev_reg[p] && in_q[p];
                afe_pkg::AFE_QUAL_HIGH:
                    accept[p] = in_q[p];
                afe_pkg::AFE_QUAL_BLANK:
                    accept[p] = 1'b1;
            endcase
            q_prev_next[p] = in_q[p];
            cap_valid_next[p] = accept[p];
            cap_data_next[p] = cap_data_reg[p];
            cap_exp_next[p] = cap_exp_reg[p];
            cap_slot_next[p] = cap_slot_reg[p];
            slot_next[p] = slot_reg[p];
            if (accept[p]) begin
                cap_data_next[p] = (mode[p] == afe_pkg::AFE_QUAL_BLANK &&
                    !in_q[p]) ? '0 : in_data[p];
                cap_exp_next[p] = in_exp[p];
                cap_slot_next[p] = ilv[p] && slot_reg[p];
                slot_next[p] = ilv[p] && !slot_reg[p];
                // Raw magnitude feeds the detectors before any filter.
                mon_next[2*p + (ilv[p] && slot_reg[p] ? 1 : 0)] =
                    afe_pkg::afe_mag(cap_data_next[p]);
                if (!ilv[p]) begin
                    mon_next[2*p+1] = afe_pkg::afe_mag(cap_data_next[p]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < 2; p++) begin
                // The pins idle high; a low history would fake a rise.
                q_prev_reg[p] <= 1'b1;
                slot_reg[p] <= 1'b0;
                cap_data_reg[p] <= '0;
                cap_exp_reg[p] <= '0;
                cap_slot_reg[p] <= 1'b0;
                cap_valid_reg[p] <= 1'b0;
                out_data_reg[p] <= '0;
                out_valid_reg[p] <= 1'b0;
            end
            for (int i = 0; i < afe_pkg::NCH; i++) begin
                mon_reg[i] <= '0;
            end
            step_reg <= 1'b0;
        end else begin
            q_prev_reg <= q_prev_next;
            slot_reg <= slot_next;
            cap_data_reg <= cap_data_next;
            cap_exp_reg <= cap_exp_next;
            cap_slot_reg <= cap_slot_next;
            cap_valid_reg <= cap_valid_next;
            out_data_reg <= scaled;
            out_valid_reg <= cap_valid_reg;
            mon_reg <= mon_next;
            // The filter steps every clock, sample or not.
            step_reg <= 1'b1;
        end
    end

    for (genvar c = 0; c < afe_pkg::NCH; c++) begin : g_det
        assign lvl[c].mag = mon_reg[lcfg_reg[c][afe_pkg::LCFG_SRC_LSB +: 2]];
        assign lvl[c].upper = thr_reg[c][afe_pkg::THR_UPPER_LSB +: DW];
        assign lvl[c].lower = thr_reg[c][afe_pkg::THR_LOWER_LSB +: DW];
        assign lvl[c].dwell = dwell_reg[c];
        assign lvl[c].dly = lcfg_reg[c][afe_pkg::LCFG_DLY_LSB +: 3];
        assign flags[c] = lvl[c].flag;
        assign gflags[c] = lvl[c].gain_flag;
        afe_level_det u_det (
            .pclk(pclk),
            .presetn(presetn),
            .lvl(lvl[c])
        );
    end

    for (genvar p = 0; p < 2; p++) begin : g_scale
        assign gsel[p] = gflags[2*p + (cap_slot_reg[p] ? 1 : 0)] ?
            scale_reg[afe_pkg::SCALE_LOUD_LSB +: afe_pkg::SCALE_W] :
            scale_reg[afe_pkg::SCALE_QUIET_LSB +: afe_pkg::SCALE_W];
        afe_scaler u_scale (
            .data_in(cap_data_reg[p]),
            .exponent_in(cap_exp_reg[p]),
            .gain_shift(gsel[p]),
            .exponent_invert(ctrl_reg[afe_pkg::CTRL_INV_BIT]),
            .data_out(scaled[p])
        );
    end

    assign port_a_even_level_flag = flags[0];
    assign port_a_odd_level_flag = flags[1];
    assign port_b_even_level_flag = flags[2];
    assign port_b_odd_level_flag = flags[3];
    assign port_a_scaled = out_data_reg[0];
    assign port_a_scaled_valid = out_valid_reg[0];
    assign port_b_scaled = out_data_reg[1];
    assign port_b_scaled_valid = out_valid_reg[1];
    assign filter_step = step_reg;

    fall_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_FALL && q_prev_reg[0] &&
        !port_a_qualify) |=> cap_valid_reg[0] ##1 port_a_scaled_valid)
        else $error("Falling qualify edge did not yield a sample.");
    rise_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_RISE && !q_prev_reg[0] &&
        port_a_qualify) |=> cap_valid_reg[0])
        else $error("Rising qualify edge did not yield a sample.");
    one_per_edge_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_RISE &&
        $past(mode[0]) == afe_pkg::AFE_QUAL_RISE && cap_valid_reg[0])
        |=> !cap_valid_reg[0])
        else $error("Two samples taken for one qualify edge.");
    level_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_HIGH && !port_a_qualify) |=>
        !cap_valid_reg[0] && $stable(cap_data_reg[0]))
        else $error("Sample taken while qualify low in level mode.");
    blank_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_BLANK && !port_a_qualify) |=>
        cap_valid_reg[0] && cap_data_reg[0] == '0)
        else $error("Blanked sample was not zero.");
    step_every_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> filter_step)
        else $error("Filter step missed a clock.");
    capture_data_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (mode[0] == afe_pkg::AFE_QUAL_HIGH && port_a_qualify) |=>
        cap_data_reg[0] == $past(port_a_data))
        else $error("Captured data differs from the port at the edge.");
    gain_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!ilv[0] && !gflags[0]) |-> gsel[0] ==
        scale_reg[afe_pkg::SCALE_QUIET_LSB +: afe_pkg::SCALE_W])
        else $error("Quiet gain not used while the level flag is clear.");
endmodule

// file: dv/afe_adc_model.sv
// Converter model: 12-bit ranging ADC on port A, 12-bit fixed ADC on B.
// Assumes the bench changes its inputs just after a rising pclk edge.
`timescale 1ns/10ps
module afe_adc_model (
    input wire logic [11:0] samp_a,
    input wire logic [2:0] exp_a,
    input wire logic [11:0] samp_b,
    output logic [13:0] port_a_data,
    output logic [2:0] port_a_exponent_in,
    output logic [13:0] port_b_data,
    output logic [2:0] port_b_exponent_in
);
    // Narrow parts sit on the top bits so full scale stays full scale.
    assign port_a_data = {samp_a, 2'b00};
    assign port_a_exponent_in = exp_a;
    assign port_b_data = {samp_b, 2'b00};
    assign port_b_exponent_in = 3'h0;
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the ADC input front end.
// Assumes the APB slave answers in its own time; samples settle quickly.
`timescale 1ns/10ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [11:0] samp_a = 12'h000, samp_b = 12'h123;
    logic [2:0] exp_a = 3'h0;
    logic [13:0] port_a_data, port_b_data, port_a_scaled;
    logic [2:0] port_a_exponent_in, port_b_exponent_in;
    logic port_a_qualify = 1'b0, port_b_qualify = 1'b1;
    logic port_a_even_level_flag, port_a_scaled_valid, filter_step;
    logic port_a_odd_level_flag, port_b_even_level_flag, port_b_odd_level_flag;
    logic [13:0] port_b_scaled;
    logic port_b_scaled_valid;
    int error_cnt = 0, checked = 0;
    always #12.5 pclk = ~pclk;
    afe_adc_model adc (.samp_a, .exp_a, .samp_b, .port_a_data,
        .port_a_exponent_in, .port_b_data, .port_b_exponent_in);
    afe_front_end dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .port_a_data,
        .port_a_exponent_in, .port_a_qualify, .port_b_data,
        .port_b_exponent_in, .port_b_qualify, .port_a_even_level_flag,
        .port_a_odd_level_flag, .port_b_even_level_flag,
        .port_b_odd_level_flag, .port_a_scaled, .port_a_scaled_valid,
        .port_b_scaled, .port_b_scaled_valid, .filter_step);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
            input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic scl(input logic [11:0] s, input logic [2:0] e,
            input int sh);
        logic [13:0] d;
        d = {s, 2'b00};
        @(posedge pclk);
        samp_a <= s;
        exp_a <= e;
        repeat (12) @(posedge pclk);
        chk({18'h0, port_a_scaled}, {18'h0, 14'($signed(d) >>> sh)});
    endtask
    task automatic qual_run(input logic [1:0] m, input logic [15:0] pat);
        int cnt, expn;
        logic prev, cur;
        apb(1'b1, 8'h90, {28'h0, 2'b10, m});
        cnt = 0;
        expn = 0;
        prev = 1'b0;
        repeat (6) @(posedge pclk);
        for (int j = 0; j < 24; j++) begin
            @(posedge pclk);
            if (port_a_scaled_valid === 1'b1) cnt++;
            cur = (j < 16) ? pat[j] : 1'b0;
            port_a_qualify <= cur;
            if (m == 2'b00) expn += int'(prev & ~cur);
            else if (m == 2'b01) expn += int'(~prev & cur);
            else expn += int'(cur);
            prev = cur;
        end
        chk(32'(cnt), 32'(expn));
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(port_a_even_level_flag), 32'h0);
        apb(1'b0, 8'h90, 32'h0);
        chk(rd, 32'h0000000A);
        apb(1'b0, 8'h98, 32'h0);
        chk(rd, 32'h3FFF0000);
        apb(1'b0, 8'hB0, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test registers done");
        for (int m = 0; m < 3; m++) qual_run(2'(m), 16'hB3C6);
        chk(32'(filter_step), 32'h1);
        apb(1'b1, 8'h90, 32'h0000000B);
        @(posedge pclk);
        samp_a <= 12'h7A1;
        repeat (12) @(posedge pclk);
        chk(32'(port_a_scaled_valid), 32'h1);
        chk({18'h0, port_a_scaled}, 32'h0);
        $display("test qualify modes done");
        port_a_qualify <= 1'b1;
        apb(1'b1, 8'h90, 32'h0000000A);
        apb(1'b1, 8'h92, {22'h0, 5'h04, 5'h01});
        apb(1'b1, 8'h98, 32'h10000400);
        apb(1'b1, 8'h9C, 32'h00000003);
        apb(1'b1, 8'h94, 32'h00000008);
        scl(12'h500, 3'h0, 1);
        chk(32'(port_a_even_level_flag), 32'h1);
        apb(1'b0, 8'hA0, 32'h0);
        chk(rd, 32'h00000011);
        chk({29'h0, port_a_odd_level_flag, port_b_even_level_flag,
            port_b_odd_level_flag}, 32'h0);
        samp_a <= 12'h010;
        repeat (2) @(posedge pclk);
        samp_a <= 12'h200;
        repeat (10) @(posedge pclk);
        chk(32'(port_a_even_level_flag), 32'h1);
        scl(12'h010, 3'h0, 4);
        chk(32'(port_a_even_level_flag), 32'h0);
        $display("test level detect done");
        apb(1'b1, 8'h92, {22'h0, 5'h1E, 5'h00});
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h90, {25'h0, 1'(i), 6'h0A});
            for (int e = 0; e < 8; e++)
                scl(12'hF9B, 3'(e), (i == 1 ? 37 - e : e + 30) % 32);
        end
        chk({18'h0, port_b_scaled}, 32'h00000024);
        chk(32'(port_b_scaled_valid), 32'h1);
        $display("test scaling done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end
endmodule
